// ### qpc_defs.vh
// register map, field positions and constants of the phase counter
`ifndef QPC_DEFS_VH
`define QPC_DEFS_VH

// register byte addresses
`define QPC_A_CTRL     8'h00
`define QPC_A_IRQEN    8'h04
`define QPC_A_FILTPS   8'h08
`define QPC_A_COUNT    8'h0c
`define QPC_A_STATUS   8'h10

// control register fields
`define QPC_C_MODE_HI  2
`define QPC_C_MODE_LO  0
`define QPC_C_ASEL     3
`define QPC_C_BSEL     4
`define QPC_C_FILEN    5
`define QPC_C_RUN      6
`define QPC_C_EVA      7
`define QPC_C_EVB      8
`define QPC_C_W        9

// interrupt enable fields
`define QPC_I_MASTER   0
`define QPC_I_CMA      1
`define QPC_I_CMB      2
`define QPC_I_OVF      3
`define QPC_I_UDF      4
`define QPC_I_TIC      5
`define QPC_I_W        6

// status fields
`define QPC_S_CMA      0
`define QPC_S_CMB      1
`define QPC_S_OVF      2
`define QPC_S_UDF      3
`define QPC_S_TIC      4
`define QPC_S_W        5

// external mode codes
`define QPC_MODE_NORM  3'h0
`define QPC_MODE_PH1   3'h1
`define QPC_MODE_PH2   3'h2
`define QPC_MODE_PH3   3'h3
`define QPC_MODE_PH4   3'h4

// counter limits and reset values
`define QPC_CNT_MAX    16'hffff
`define QPC_CNT_ZERO   16'h0000
`define QPC_CNT_ONE    16'h0001
`define QPC_FPS_ZERO   8'h00
`define QPC_FPS_ONE    8'h01
`define QPC_RD_ZERO    16'h0000

`endif

// ### qpc_counter.v
// phase-counting front end of one 16-bit timer channel
`timescale 1ns/1ps
`default_nettype none
`include "qpc_defs.vh"

// Function
// RQ1 - mode field codes 1..4 select phase counting modes one to four
// RQ2 - phase A source select picks comparator output over phase A pin
// RQ3 - phase B source select picks comparator output over phase B pin
// RQ4 - mode 1 counts on every edge of A and B by quadrature direction
// RQ5 - mode 2 counts only on A falling, up if B high, down if low
// RQ6 - mode 3: A falling with B high up, B falling with A high down
// RQ7 - mode 4 counts on B edges only, direction from A level
// RQ8 - with filter on, pass level only when three samples agree
// RQ9 - filter sampling rate comes from filter prescale register
// RQ10 - with filter off, inputs pass a two flip-flop synchroniser
// RQ11 - channel gives one interrupt request and events A and B
// RQ12 - interrupt needs master enable and an enabled pending source
// RQ13 - A enable lets compare match or capture A raise interrupt
// RQ14 - B enable lets compare match or capture B raise interrupt
// RQ15 - overflow enable lets counter overflow raise interrupt
// RQ16 - underflow enable lets underflow raise interrupt, phase modes only
// RQ17 - trigger enable lets external trigger event raise interrupt
// RQ18 - status records each source; writing one clears, zero keeps
// RQ19 - event A only from register A, event B only from register B
// RQ20 - events A and B are independent and may fire together
// RQ21 - counting up from ffff wraps to zero and sets overflow
// RQ22 - prescaler tick paces counting in phase modes as well
// RQ23 - counting down from zero wraps to ffff and sets underflow
// RQ24 - edges from level versus previous cycle; one step per cycle
module qpc_counter (
  // clock and reset
  input  wire        clk_in,
  input  wire        rst_n_in,
  // register port
  input  wire [7:0]  reg_addr_in,
  input  wire [15:0] reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [15:0] reg_rdata_out,
  // phase inputs, asynchronous
  input  wire        phase_input_a_in,
  input  wire        phase_input_b_in,
  input  wire        comparator_a_in,
  input  wire        comparator_b_in,
  // channel events, same clock
  input  wire        prescale_tick_in,
  input  wire        match_a_in,
  input  wire        match_b_in,
  input  wire        capture_a_in,
  input  wire        capture_b_in,
  input  wire        ext_trigger_in,
  input  wire        counter_clear_in,
  // outputs
  output reg  [15:0] count_value_out,
  output reg         overflow_out,
  output reg         irq_out,
  output reg         event_a_out,
  output reg         event_b_out
);

  // --------------------------------------------------------------
  // step decode
  // --------------------------------------------------------------

  // returns {up, down}; a level counts only if that line is steady
  function [1:0] qpc_step;
    input [2:0] mode;
    input       a_old;
    input       a_now;
    input       b_old;
    input       b_old_unused;
    input       b_now;
    reg ar, af, br, bf, as, bs, up, dn;
    begin
      ar = ~a_old & a_now;
      af = a_old & ~a_now;
      br = ~b_old & b_now;
      bf = b_old & ~b_now;
      as = ~(ar | af);
      bs = ~(br | bf);
      up = 1'b0;
      dn = 1'b0;
      case (mode)
        // RQ4 mode one table
        `QPC_MODE_PH1: begin
          up = (as & ((br & a_now) | (bf & ~a_now)))
             | (bs & ((ar & ~b_now) | (af & b_now)));
          dn = (as & ((bf & a_now) | (br & ~a_now)))
             | (bs & ((ar & b_now) | (af & ~b_now)));
        end
        // RQ5 mode two table
        `QPC_MODE_PH2: begin
          up = bs & af & b_now;
          dn = bs & af & ~b_now;
        end
        // RQ6 mode three table
        `QPC_MODE_PH3: begin
          up = bs & af & b_now;
          dn = as & bf & a_now;
        end
        // RQ7 mode four table
        `QPC_MODE_PH4: begin
          up = as & ((br & a_now) | (bf & ~a_now));
          dn = as & ((bf & a_now) | (br & ~a_now));
        end
        default: begin
          up = 1'b0;
          dn = 1'b0;
        end
      endcase
      qpc_step = {up, dn};
    end
  endfunction

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------

  reg [`QPC_C_W-1:0] ctrl;
  reg [`QPC_I_W-1:0] irqen;
  reg [`QPC_S_W-1:0] status;
  reg [7:0]          filt_ps;

  wire [2:0] mode     = ctrl[`QPC_C_MODE_HI:`QPC_C_MODE_LO];
  wire       filen    = ctrl[`QPC_C_FILEN];
  // RQ1 phase mode decode
  wire       ph_mode  = (mode >= `QPC_MODE_PH1) && (mode <= `QPC_MODE_PH4);
  wire       wr_cnt   = reg_wr_in && (reg_addr_in == `QPC_A_COUNT);

  // --------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------

  reg [1:0] sync_a1;
  reg [1:0] sync_a2;
  reg [1:0] sync_b1;
  reg [1:0] sync_b2;

  // both pin and comparator paths are synchronised before the mux
  // so that a source switch never feeds a raw async level inward
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_a1 <= 2'h0;
      sync_a2 <= 2'h0;
      sync_b1 <= 2'h0;
      sync_b2 <= 2'h0;
    end else begin
      // RQ10 two stage sync
      sync_a1 <= {comparator_a_in, phase_input_a_in};
      sync_a2 <= sync_a1;
      sync_b1 <= {comparator_b_in, phase_input_b_in};
      sync_b2 <= sync_b1;
    end
  end

  // RQ2 phase A source
  wire src_a = ctrl[`QPC_C_ASEL] ? sync_a2[1] : sync_a2[0];
  // RQ3 phase B source
  wire src_b = ctrl[`QPC_C_BSEL] ? sync_b2[1] : sync_b2[0];

  // --------------------------------------------------------------
  // noise filter
  // --------------------------------------------------------------

  reg [7:0] fdiv;
  reg       fsample;
  reg [2:0] hist_a;
  reg [2:0] hist_b;
  reg       filt_a;
  reg       filt_b;

  // RQ9 sample strobe every filt_ps plus one clocks
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fdiv    <= `QPC_FPS_ZERO;
      fsample <= 1'b0;
    end else if (fdiv >= filt_ps) begin
      fdiv    <= `QPC_FPS_ZERO;
      fsample <= 1'b1;
    end else begin
      fdiv    <= fdiv + `QPC_FPS_ONE;
      fsample <= 1'b0;
    end
  end

  // RQ8 three sample vote
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hist_a <= 3'h0;
      hist_b <= 3'h0;
      filt_a <= 1'b0;
      filt_b <= 1'b0;
    end else begin
      if (fsample) begin
        hist_a <= {hist_a[1:0], src_a};
        hist_b <= {hist_b[1:0], src_b};
      end
      // level only moves once all three samples agree
      if (&hist_a)
        filt_a <= 1'b1;
      else if (~|hist_a)
        filt_a <= 1'b0;
      if (&hist_b)
        filt_b <= 1'b1;
      else if (~|hist_b)
        filt_b <= 1'b0;
    end
  end

  // RQ10 bypass when filter off
  wire lvl_a = filen ? filt_a : src_a;
  wire lvl_b = filen ? filt_b : src_b;

  // --------------------------------------------------------------
  // edge detection and pacing
  // --------------------------------------------------------------

  reg  prev_a;
  reg  prev_b;
  reg  pend_up;
  reg  pend_dn;

  // RQ24 compare with previous cycle
  wire [1:0] step = qpc_step(mode, prev_a, lvl_a, prev_b, prev_b, lvl_b);

  // a held step cancels against an opposite new one; a step of the
  // same sign while one waits is dropped, so ticks must outpace edges
  wire now_up = pend_up | (step[1] & ~pend_dn);
  wire now_dn = pend_dn | (step[0] & ~pend_up);
  wire cancel = (pend_up & step[0]) | (pend_dn & step[1]);

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_a  <= 1'b0;
      prev_b  <= 1'b0;
      pend_up <= 1'b0;
      pend_dn <= 1'b0;
    end else begin
      prev_a <= lvl_a;
      prev_b <= lvl_b;
      // RQ22 hold step until tick
      if (!ph_mode || cancel || prescale_tick_in || wr_cnt) begin
        pend_up <= 1'b0;
        pend_dn <= 1'b0;
      end else begin
        pend_up <= now_up;
        pend_dn <= now_dn;
      end
    end
  end

  // --------------------------------------------------------------
  // counter
  // --------------------------------------------------------------

  wire run    = ctrl[`QPC_C_RUN];
  wire go_up  = run & prescale_tick_in &
                (ph_mode ? (now_up & ~cancel) : 1'b1);
  wire go_dn  = run & prescale_tick_in & ph_mode & now_dn & ~cancel;
  // RQ21 overflow at top
  wire ovf_ev = go_up && (count_value_out == `QPC_CNT_MAX);
  // RQ23 underflow at zero
  wire udf_ev = go_dn && (count_value_out == `QPC_CNT_ZERO);

  // software write beats clear, clear beats a count step
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_value_out <= `QPC_CNT_ZERO;
      overflow_out    <= 1'b0;
    end else begin
      overflow_out <= ovf_ev & ~wr_cnt & ~counter_clear_in;
      if (wr_cnt)
        count_value_out <= reg_wdata_in;
      else if (counter_clear_in)
        count_value_out <= `QPC_CNT_ZERO;
      // RQ24 single step per cycle
      else if (go_up)
        count_value_out <= count_value_out + `QPC_CNT_ONE;
      else if (go_dn)
        count_value_out <= count_value_out - `QPC_CNT_ONE;
    end
  end

  // --------------------------------------------------------------
  // status, interrupt and events
  // --------------------------------------------------------------

  wire src_cma = match_a_in | capture_a_in;
  wire src_cmb = match_b_in | capture_b_in;
  wire [`QPC_S_W-1:0] set_v;
  wire [`QPC_S_W-1:0] clr_v;
  wire [`QPC_S_W-1:0] next_status;

  assign set_v[`QPC_S_CMA] = src_cma;
  assign set_v[`QPC_S_CMB] = src_cmb;
  assign set_v[`QPC_S_OVF] = ovf_ev & ~wr_cnt & ~counter_clear_in;
  // RQ16 underflow in phase modes
  assign set_v[`QPC_S_UDF] = udf_ev & ~wr_cnt & ~counter_clear_in;
  assign set_v[`QPC_S_TIC] = ext_trigger_in;
  // RQ18 write one clears
  assign clr_v = (reg_wr_in && reg_addr_in == `QPC_A_STATUS) ?
                 reg_wdata_in[`QPC_S_W-1:0] : {`QPC_S_W{1'b0}};
  // RQ18 set wins over clear
  assign next_status = (status & ~clr_v) | set_v;

  // RQ13 A source gate
  wire en_cma = irqen[`QPC_I_CMA] & next_status[`QPC_S_CMA];
  // RQ14 B source gate
  wire en_cmb = irqen[`QPC_I_CMB] & next_status[`QPC_S_CMB];
  // RQ15 overflow gate
  wire en_ovf = irqen[`QPC_I_OVF] & next_status[`QPC_S_OVF];
  // RQ16 underflow gate
  wire en_udf = irqen[`QPC_I_UDF] & next_status[`QPC_S_UDF];
  // RQ17 trigger gate
  wire en_tic = irqen[`QPC_I_TIC] & next_status[`QPC_S_TIC];

  // RQ11 one irq, two events
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status      <= {`QPC_S_W{1'b0}};
      irq_out     <= 1'b0;
      event_a_out <= 1'b0;
      event_b_out <= 1'b0;
    end else begin
      status <= next_status;
      // RQ12 master enable gate
      irq_out <= irqen[`QPC_I_MASTER] &
                 (en_cma | en_cmb | en_ovf | en_udf | en_tic);
      // RQ19 event per register
      event_a_out <= ctrl[`QPC_C_EVA] & src_cma;
      // RQ20 independent events
      event_b_out <= ctrl[`QPC_C_EVB] & src_cmb;
    end
  end

  // --------------------------------------------------------------
  // register port
  // --------------------------------------------------------------

  // control writes take effect next cycle
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl    <= {`QPC_C_W{1'b0}};
      irqen   <= {`QPC_I_W{1'b0}};
      filt_ps <= `QPC_FPS_ZERO;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `QPC_A_CTRL:   ctrl    <= reg_wdata_in[`QPC_C_W-1:0];
        `QPC_A_IRQEN:  irqen   <= reg_wdata_in[`QPC_I_W-1:0];
        `QPC_A_FILTPS: filt_ps <= reg_wdata_in[7:0];
        default: begin
          filt_ps <= filt_ps;
        end
      endcase
    end
  end

  // read data valid in the cycle after the strobe only
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= `QPC_RD_ZERO;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `QPC_A_CTRL:   reg_rdata_out <= {7'h0, ctrl};
        `QPC_A_IRQEN:  reg_rdata_out <= {10'h0, irqen};
        `QPC_A_FILTPS: reg_rdata_out <= {8'h0, filt_ps};
        `QPC_A_COUNT:  reg_rdata_out <= count_value_out;
        `QPC_A_STATUS: reg_rdata_out <= {11'h0, status};
        default:       reg_rdata_out <= `QPC_RD_ZERO;
      endcase
    end else begin
      reg_rdata_out <= `QPC_RD_ZERO;
    end
  end

endmodule // qpc_counter

`default_nettype wire

// ### qpc_counter_chk.sv
// concurrent checks on the phase counter ports
`timescale 1ns/1ps
`default_nettype none
module qpc_counter_chk (
  // watched ports
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic        match_a_in,
  input wire logic        match_b_in,
  input wire logic        capture_a_in,
  input wire logic        capture_b_in,
  input wire logic        ext_trigger_in,
  input wire logic        counter_clear_in,
  input wire logic [15:0] count_value_out,
  input wire logic        overflow_out,
  input wire logic        irq_out,
  input wire logic        event_a_out,
  input wire logic        event_b_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // an unforced step off the top of the range
  sequence s_up_wrap;
    (count_value_out == 16'hffff && !reg_wr_in && !counter_clear_in)
      ##1 count_value_out == 16'h0000;
  endsequence
  // underflow shows as a zero to all-ones move
  sequence s_down_wrap;
    count_value_out == 16'hffff && $past(count_value_out) == 16'h0000;
  endsequence
  property p_rd_idle;
    !reg_rd_in |=> reg_rdata_out == 16'h0000;
  endproperty
  property p_ev_a;
    !(match_a_in || capture_a_in) |=> !event_a_out;
  endproperty
  property p_ev_b;
    !(match_b_in || capture_b_in) |=> !event_b_out;
  endproperty
  property p_ovf_wrap;
    overflow_out |-> count_value_out == 16'h0000 && $past(count_value_out) == 16'hffff;
  endproperty
  property p_wrap_ovf;
    s_up_wrap |-> overflow_out;
  endproperty
  // writes and clears may jump, nothing else may
  property p_one_step;
    !$past(reg_wr_in) && !$past(counter_clear_in) |->
      (count_value_out - $past(count_value_out)) inside {16'h0000, 16'h0001, 16'hffff};
  endproperty
  property p_irq_cause;
    $rose(irq_out) |-> ($past(reg_wr_in) || $past(reg_wr_in, 2) || overflow_out
      || $past(match_a_in || match_b_in || capture_a_in || capture_b_in || ext_trigger_in))
      or s_down_wrap;
  endproperty
  property p_irq_hold;
    irq_out && !reg_wr_in && !$past(reg_wr_in) |=> irq_out;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_ev_a: assert property (p_ev_a) else $error("event a without its source");
  a_ev_b: assert property (p_ev_b) else $error("event b without its source");
  a_ovf_wrap: assert property (p_ovf_wrap) else $error("overflow without wrap");
  a_wrap_ovf: assert property (p_wrap_ovf) else $error("wrap without overflow");
  a_one_step: assert property (p_one_step) else $error("count moved by more than one");
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt with no cause");
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped untouched");
  c_both: cover property (event_a_out && event_b_out);
endmodule // qpc_counter_chk
`default_nettype wire

// ### qpc_enc_model.sv
// encoder pins and comparator outputs feeding the phase counter
`timescale 1ns/1ps
`default_nettype none
module qpc_enc_model (
  // clock, wanted levels and source selects
  input  wire logic clk_in,
  input  wire logic lvl_a_in,
  input  wire logic lvl_b_in,
  input  wire logic sel_a_in,
  input  wire logic sel_b_in,
  // both sources of each phase
  output wire logic pin_a_out,
  output wire logic pin_b_out,
  output wire logic cmp_a_out,
  output wire logic cmp_b_out
);
  logic noise = 1'b0;
  // the unused source toggles, so picking the wrong one shows
  always @(posedge clk_in) noise <= ~noise;
  assign pin_a_out = sel_a_in ? noise : lvl_a_in;
  assign cmp_a_out = sel_a_in ? lvl_a_in : noise;
  assign pin_b_out = sel_b_in ? noise : lvl_b_in;
  assign cmp_b_out = sel_b_in ? lvl_b_in : noise;
endmodule // qpc_enc_model
`default_nettype wire

// ### qpc_counter_tb_top.sv
// self-checking bench of the phase counter
`timescale 1ns/1ps
`default_nettype none
module qpc_counter_tb_top;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, tick = 0, pace = 0, clr = 0;
  logic        la = 0, lb = 0, sa = 0, sb = 0;
  logic [7:0]  addr = 0;
  logic [15:0] wd = 0, rv, e;
  logic [4:0]  src = 0;
  wire         pa, pb, ca, cb, ovf, irq, eva, evb;
  wire  [15:0] cnt, rdat;
  int          failures = 0, checks = 0, cyc = 0;
  logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  logic [15:0] msk [3] = '{16'h01ff, 16'h003f, 16'h00ff};
  logic [15:0] sbit [5] = '{16'h0001, 16'h0002, 16'h0001, 16'h0002, 16'h0010};
  initial forever #2.5 clk = ~clk;
  qpc_enc_model u_enc (.clk_in(clk), .lvl_a_in(la), .lvl_b_in(lb), .sel_a_in(sa),
    .sel_b_in(sb), .pin_a_out(pa), .pin_b_out(pb), .cmp_a_out(ca), .cmp_b_out(cb));
  qpc_counter DUT (.clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .phase_input_a_in(pa),
    .phase_input_b_in(pb), .comparator_a_in(ca), .comparator_b_in(cb),
    .prescale_tick_in(tick), .match_a_in(src[0]), .match_b_in(src[1]),
    .capture_a_in(src[2]), .capture_b_in(src[3]), .ext_trigger_in(src[4]),
    .counter_clear_in(clr), .count_value_out(cnt), .overflow_out(ovf), .irq_out(irq),
    .event_a_out(eva), .event_b_out(evb));
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // run ceiling, and a paced tick every fourth clock in phase runs
  always @(posedge clk) begin
    cyc++;
    if (pace) tick <= (cyc % 4 == 0);
    if (cyc == 40000) begin
      failures++;
      give_verdict;
    end
  end
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    checks++;
    if (g !== x) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wd <= d;
    wr <= 1;
    @(posedge clk) wr <= 0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [7:0] a, output logic [15:0] v);
    addr <= a;
    rd <= 1;
    @(posedge clk) rd <= 0;
    #1 v = rdat;
    @(posedge clk);
  endtask
  // expected step for one line changing: up 0001, down ffff
  function automatic logic [15:0] stp(input int m, input logic ao, an, bo, bn);
    if (ao != an && (m == 1 || m == 2 && !an || m == 3 && !an && bn))
      return ((m == 1) ? an != bn : bn) ? 16'h0001 : 16'hffff;
    if (bo != bn && (m == 1 || m == 4 || m == 3 && !bn && an))
      return ((m == 3) ? 1'b0 : an == bn) ? 16'h0001 : 16'hffff;
    return 16'h0000;
  endfunction
  // random single-line moves, with a short glitch first when filtering
  task automatic phase(input int m, input int s, input int f);
    logic [7:0] ps;
    int h;
    ps = 8'($urandom % 4);
    h = f ? (ps + 1) * 4 + 8 : 8;
    sa <= s[0];
    sb <= s[1];
    wreg(8'h08, {8'h00, ps});
    wreg(8'h00, 16'(m + s * 8 + f * 32 + 64));
    cy(h);
    wreg(8'h0c, 16'h8000);
    e = 16'h8000;
    for (int k = 0; k < 24; k++) begin
      if (f) begin
        la <= ~la;
        @(posedge clk) la <= ~la;
        cy(h);
      end
      if ($urandom % 2) begin
        e += stp(m, la, la, lb, ~lb);
        lb <= ~lb;
      end else begin
        e += stp(m, la, ~la, lb, lb);
        la <= ~la;
      end
      cy(h);
    end
    rreg(8'h0c, rv);
    chk("phase count", e, rv);
  endtask
  initial begin
    void'($urandom(59011));
    repeat (5) @(posedge clk);
    rst_n <= 1;
    foreach (ra[i]) begin
      rreg(ra[i], rv);
      chk("reset value", 16'h0000, rv);
    end
    for (int i = 0; i < 4; i++) begin
      e = 16'($urandom);
      wreg(ra[i % 3 + 3 * (i / 3) * 2 - (i / 3)], e);
      rreg(ra[i % 3 + 3 * (i / 3) * 2 - (i / 3)], rv);
      chk("read back", (i < 3) ? e & msk[i] : 16'h0000, rv);
    end
    // free counting on random ticks
    wreg(8'h0c, 16'h1234);
    wreg(8'h00, 16'h0040);
    e = 16'h1234;
    repeat (40) begin
      wd <= 16'($urandom % 2);
      tick <= wd[0];
      e += 16'(wd[0]);
      @(posedge clk);
    end
    tick <= 0;
    cy(1);
    rreg(8'h0c, rv);
    chk("free count", e, rv);
    chk("count port", e, cnt);
    wreg(8'h04, 16'h0009);
    wreg(8'h0c, 16'hffff);
    tick <= 1;
    @(posedge clk) tick <= 0;
    #1 chk("overflow pulse", 16'h0001, 16'(ovf));
    rreg(8'h10, rv);
    chk("overflow flag", 16'h0004, rv);
    chk("overflow irq", 16'h0001, 16'(irq));
    wreg(8'h10, 16'h001f);
    // a clear beats a wrapping step and hides its overflow
    wreg(8'h0c, 16'hffff);
    tick <= 1;
    clr <= 1;
    @(posedge clk) tick <= 0;
    clr <= 0;
    #1 chk("clear no overflow", 16'h0000, 16'(ovf));
    chk("clear count", 16'h0000, cnt);
    rreg(8'h10, rv);
    chk("clear no flag", 16'h0000, rv);
    wreg(8'h00, 16'h0180);
    for (int i = 0; i < 5; i++) begin
      wreg(8'h04, 16'h0001);
      src[i] <= 1;
      @(posedge clk) src[i] <= 0;
      #1 chk("event a", 16'(i == 0 || i == 2), 16'(eva));
      chk("event b", 16'(i == 1 || i == 3), 16'(evb));
      chk("irq masked", 16'h0000, 16'(irq));
      wreg(8'h04, 16'h0001 | (sbit[i] << 1));
      wreg(8'h10, 16'h0000);
      rreg(8'h10, rv);
      chk("status", sbit[i], rv);
      chk("irq", 16'h0001, 16'(irq));
      wreg(8'h10, sbit[i]);
      #1 chk("irq cleared", 16'h0000, 16'(irq));
    end
    src <= 5'b00011;
    @(posedge clk) src <= 0;
    #1 chk("both events", 16'h0003, {14'h0000, evb, eva});
    wreg(8'h10, 16'h001f);
    pace <= 1;
    for (int m = 1; m < 5; m++)
      for (int s = 0; s < 4; s++)
        phase(m, s, (m + s) % 2);
    sa <= 0;
    sb <= 0;
    la <= 1;
    lb <= 1;
    wreg(8'h00, 16'h0044);
    cy(10);
    wreg(8'h04, 16'h0011);
    wreg(8'h10, 16'h001f);
    wreg(8'h0c, 16'h0000);
    lb <= 0;
    cy(10);
    rreg(8'h0c, rv);
    chk("underflow count", 16'hffff, rv);
    rreg(8'h10, rv);
    chk("underflow flag", 16'h0008, rv);
    chk("underflow irq", 16'h0001, 16'(irq));
    give_verdict;
  end
endmodule // qpc_counter_tb_top
bind qpc_counter qpc_counter_chk u_chk (.*);
`default_nettype wire
